// ===== inc/fcd_params.svh
`ifndef FCD_PARAMS_SVH
`define FCD_PARAMS_SVH

`define FCD_AW 22
`define FCD_DW 16
`define FCD_A_UNLK1 12'h555
`define FCD_A_UNLK2 12'h2aa
`define FCD_A_ANY 12'h000
`define FCD_A_QUERY 12'h055
`define FCD_D_UNLK1 8'haa
`define FCD_D_UNLK2 8'h55
`define FCD_D_RESET 8'hf0
`define FCD_D_AUTOSEL 8'h90
`define FCD_D_PROG 8'ha0
`define FCD_D_BUFLOAD 8'h25
`define FCD_D_COMMIT 8'h29
`define FCD_D_BYPASS 8'h20
`define FCD_D_BYP_EXIT 8'h00
`define FCD_D_ERASE_SETUP 8'h80
`define FCD_D_CHIP 8'h10
`define FCD_D_SECTOR 8'h30
`define FCD_D_SUSPEND 8'hb0
`define FCD_D_RESUME 8'h30
`define FCD_D_QUERY 8'h98
`define FCD_SECT_LSB 15
`define FCD_PAGE_BITS 4
`define FCD_WC_MAX 5'h0f
`define FCD_CLK_MHZ 250
`define FCD_T_WP_NS 35
`define FCD_T_ACC_NS 90
`define FCD_SYNC_CYC 2
`define FCD_WP_CYC ((`FCD_T_WP_NS * `FCD_CLK_MHZ + 999) / 1000)
`define FCD_ACC_CYC ((`FCD_T_ACC_NS * `FCD_CLK_MHZ + 999) / 1000)
`define FCD_RD_CYC (`FCD_ACC_CYC + `FCD_SYNC_CYC + 1)

`endif

// ===== inc/fcd_pkg.sv
package fcd_pkg;

  typedef enum logic [3:0] {
    FCD_READ, FCD_RESET, FCD_AUTOSEL, FCD_PROGRAM, FCD_BUFWR, FCD_BUFABORT,
    FCD_BYP_ENTER, FCD_BYP_PROG, FCD_BYP_EXIT, FCD_CHIP_ERASE,
    FCD_SECT_ERASE, FCD_SUSPEND, FCD_RESUME, FCD_QUERY
  } fcd_cmd_e;

  typedef enum logic [1:0] {
    SEL_CONST, SEL_USER, SEL_SECTOR, SEL_COUNT
  } fcd_sel_e;

  typedef struct packed {
    logic last;
    logic rd;
    fcd_sel_e asel;
    fcd_sel_e dsel;
    logic [11:0] ac;
    logic [7:0] dc;
  } fcd_step_s;

endpackage

// ===== core/fcd_bus_cycle.sv
`timescale 1ns/1ps
`include "fcd_params.svh"

module fcd_bus_cycle import fcd_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_rd,
  input wire logic [21:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_dq,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [21:0] o_addr,
  output logic [15:0] o_dq,
  output logic o_dq_oe_n
);

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_PULSE, BC_HOLD} fcd_bst_e;

  fcd_bst_e st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic done_q, done_d;
  logic [15:0] rdata_q, rdata_d;
  logic ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
  logic [21:0] addr_q, addr_d;
  logic [15:0] dq_q, dq_d;
  logic dq_oe_n_q, dq_oe_n_d;
  logic [15:0] sync1_q, sync2_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    ce_n_d = ce_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    addr_d = addr_q;
    dq_d = dq_q;
    dq_oe_n_d = dq_oe_n_q;
    case (st_q)
      BC_IDLE: begin
        if (i_start) begin
          // Address set before the strobe falls
          addr_d = i_addr;
          dq_d = i_wdata;
          rd_d = i_rd;
          ce_n_d = 1'b0;
          dq_oe_n_d = i_rd;
          st_d = BC_SETUP;
        end
      end
      BC_SETUP: begin
        we_n_d = rd_q;
        oe_n_d = ~rd_q;
        cnt_d = rd_q ? 5'(`FCD_RD_CYC - 1) : 5'(`FCD_WP_CYC - 1);
        st_d = BC_PULSE;
      end
      BC_PULSE: begin
        if (cnt_q == 5'h00) begin
          if (rd_q) begin
            rdata_d = sync2_q;
          end
          // Data still driven as the strobe rises
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          st_d = BC_HOLD;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      default: begin
        ce_n_d = 1'b1;
        dq_oe_n_d = 1'b1;
        done_d = 1'b1;
        st_d = BC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= BC_IDLE;
      cnt_q <= 5'h00;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      addr_q <= 22'h000000;
      dq_q <= 16'h0000;
      dq_oe_n_q <= 1'b1;
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      dq_oe_n_q <= dq_oe_n_d;
      sync1_q <= i_dq;
      sync2_q <= sync1_q;
    end
  end

  assign o_done = done_q;
  assign o_rdata = rdata_q;
  assign o_ce_n = ce_n_q;
  assign o_we_n = we_n_q;
  assign o_oe_n = oe_n_q;
  assign o_addr = addr_q;
  assign o_dq = dq_q;
  assign o_dq_oe_n = dq_oe_n_q;

endmodule

// ===== core/fcd_host.sv
`timescale 1ns/1ps
`include "fcd_params.svh"

module fcd_host import fcd_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input fcd_cmd_e i_cmd,
  input wire logic [21:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic [4:0] i_count,
  output logic o_cmd_ready,
  output logic o_cmd_refused,
  output logic o_done,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_word_valid,
  input wire logic [21:0] i_word_addr,
  input wire logic [15:0] i_word_data,
  output logic o_word_ready,
  output logic o_bypass,
  output logic o_autosel,
  output logic o_suspended,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [21:0] o_addr,
  output logic [15:0] o_dq,
  output logic o_dq_oe_n,
  input wire logic [15:0] i_dq
);

  ////////////////////////////////////////////////////////////////////////////
  // Command sequence table

  function automatic fcd_step_s step_of(input fcd_cmd_e c,
                                        input logic [2:0] i);
    fcd_step_s s;
    s.last = 1'b0;
    s.rd = 1'b0;
    s.asel = SEL_CONST;
    s.dsel = SEL_CONST;
    s.ac = `FCD_A_ANY;
    s.dc = `FCD_D_RESET;
    // Shared unlock pair, also the second pair of the erase sequences
    if (i == 3'd0 || i == 3'd3) begin
      s.ac = `FCD_A_UNLK1;
      s.dc = `FCD_D_UNLK1;
    end else if (i == 3'd1 || i == 3'd4) begin
      s.ac = `FCD_A_UNLK2;
      s.dc = `FCD_D_UNLK2;
    end
    case (c)
      FCD_READ: begin
        s.rd = 1'b1;
        s.asel = SEL_USER;
        s.last = 1'b1;
      end
      FCD_RESET: begin
        s.ac = `FCD_A_ANY;
        s.dc = `FCD_D_RESET;
        s.last = 1'b1;
      end
      FCD_AUTOSEL: begin
        if (i == 3'd2) begin
          s.ac = `FCD_A_UNLK1;
          s.dc = `FCD_D_AUTOSEL;
        end else if (i == 3'd3) begin
          // Offset picks maker, device, sector or region data
          s.rd = 1'b1;
          s.asel = SEL_USER;
          s.last = 1'b1;
        end
      end
      FCD_PROGRAM: begin
        if (i == 3'd2) begin
          s.ac = `FCD_A_UNLK1;
          s.dc = `FCD_D_PROG;
        end else if (i == 3'd3) begin
          s.asel = SEL_USER;
          s.dsel = SEL_USER;
          s.last = 1'b1;
        end
      end
      FCD_BUFWR: begin
        if (i == 3'd2) begin
          s.asel = SEL_SECTOR;
          s.dc = `FCD_D_BUFLOAD;
        end else if (i == 3'd3) begin
          s.asel = SEL_SECTOR;
          s.dsel = SEL_COUNT;
          s.last = 1'b1;
        end
      end
      FCD_BUFABORT: begin
        if (i == 3'd2) begin
          s.ac = `FCD_A_UNLK1;
          s.dc = `FCD_D_RESET;
          s.last = 1'b1;
        end
      end
      FCD_BYP_ENTER: begin
        if (i == 3'd2) begin
          s.ac = `FCD_A_UNLK1;
          s.dc = `FCD_D_BYPASS;
          s.last = 1'b1;
        end
      end
      FCD_BYP_PROG: begin
        if (i == 3'd0) begin
          s.ac = `FCD_A_ANY;
          s.dc = `FCD_D_PROG;
        end else begin
          s.asel = SEL_USER;
          s.dsel = SEL_USER;
          s.last = 1'b1;
        end
      end
      FCD_BYP_EXIT: begin
        s.ac = `FCD_A_ANY;
        s.dc = (i == 3'd0) ? `FCD_D_AUTOSEL : `FCD_D_BYP_EXIT;
        s.last = (i != 3'd0);
      end
      FCD_CHIP_ERASE, FCD_SECT_ERASE: begin
        if (i == 3'd2) begin
          s.ac = `FCD_A_UNLK1;
          s.dc = `FCD_D_ERASE_SETUP;
        end else if (i == 3'd5) begin
          s.last = 1'b1;
          s.ac = `FCD_A_UNLK1;
          s.dc = `FCD_D_CHIP;
          if (c == FCD_SECT_ERASE) begin
            s.asel = SEL_SECTOR;
            s.dc = `FCD_D_SECTOR;
          end
        end
      end
      FCD_SUSPEND: begin
        s.ac = `FCD_A_ANY;
        s.dc = `FCD_D_SUSPEND;
        s.last = 1'b1;
      end
      FCD_RESUME: begin
        s.ac = `FCD_A_ANY;
        s.dc = `FCD_D_RESUME;
        s.last = 1'b1;
      end
      default: begin
        s.ac = `FCD_A_QUERY;
        s.dc = `FCD_D_QUERY;
        s.last = 1'b1;
      end
    endcase
    return s;
  endfunction

  function automatic logic [21:0] sector_of(input logic [21:0] a);
    sector_of = {a[21:`FCD_SECT_LSB], 15'h0000};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  typedef enum logic [2:0] {
    M_IDLE, M_ISSUE, M_WAIT, M_WORD, M_WWAIT
  } fcd_mst_e;

  fcd_mst_e st_q, st_d;
  fcd_cmd_e cmd_q, cmd_d;
  logic [21:0] addr_q, addr_d;
  logic [15:0] data_q, data_d;
  logic [3:0] count_q, count_d;
  logic [2:0] idx_q, idx_d;
  logic [4:0] left_q, left_d;
  logic [17:0] page_q, page_d;
  logic first_q, first_d, commit_q, commit_d, last_q, last_d;
  logic start_q, start_d, b_rd_q, b_rd_d;
  logic [21:0] b_addr_q, b_addr_d;
  logic [15:0] b_data_q, b_data_d;
  logic ready_q, ready_d, refused_q, refused_d, done_q, done_d;
  logic [15:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d, wready_q, wready_d;
  logic bypass_q, bypass_d, autosel_q, autosel_d;
  logic erase_q, erase_d, susp_q, susp_d;
  logic bus_done;
  logic [15:0] bus_rdata;
  fcd_step_s st;
  logic refuse;

  always_comb begin
    st = step_of(cmd_q, idx_q);
    refuse = 1'b0;
    if (bypass_q) begin
      refuse = !(i_cmd inside {FCD_READ, FCD_BYP_PROG, FCD_BYP_EXIT});
    end else if (i_cmd == FCD_BYP_PROG) begin
      refuse = 1'b1;
    end else if (i_cmd == FCD_BUFWR && i_count > `FCD_WC_MAX) begin
      refuse = 1'b1;
    end else if (i_cmd == FCD_SUSPEND && !erase_q) begin
      refuse = 1'b1;
    end else if (i_cmd == FCD_RESUME && !susp_q) begin
      refuse = 1'b1;
    end else if (i_cmd == FCD_QUERY && erase_q) begin
      refuse = 1'b1;
    end
  end

  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    data_d = data_q;
    count_d = count_q;
    idx_d = idx_q;
    left_d = left_q;
    page_d = page_q;
    first_d = first_q;
    commit_d = commit_q;
    last_d = last_q;
    start_d = 1'b0;
    b_rd_d = b_rd_q;
    b_addr_d = b_addr_q;
    b_data_d = b_data_q;
    ready_d = ready_q;
    refused_d = 1'b0;
    done_d = 1'b0;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    wready_d = wready_q;
    bypass_d = bypass_q;
    autosel_d = autosel_q;
    erase_d = erase_q;
    susp_d = susp_q;
    case (st_q)
      M_IDLE: begin
        if (i_cmd_valid && ready_q) begin
          if (refuse) begin
            refused_d = 1'b1;
          end else begin
            cmd_d = i_cmd;
            addr_d = i_addr;
            data_d = i_data;
            count_d = i_count[3:0];
            idx_d = 3'd0;
            commit_d = 1'b0;
            ready_d = 1'b0;
            st_d = M_ISSUE;
          end
        end
      end
      M_ISSUE: begin
        b_rd_d = st.rd;
        last_d = st.last;
        // Upper address and data bits held low on unlock cycles
        b_addr_d = {10'h000, st.ac};
        b_data_d = {8'h00, st.dc};
        if (st.asel == SEL_USER) begin
          b_addr_d = addr_q;
        end else if (st.asel == SEL_SECTOR) begin
          b_addr_d = sector_of(addr_q);
        end
        if (st.dsel == SEL_USER) begin
          b_data_d = data_q;
        end else if (st.dsel == SEL_COUNT) begin
          b_data_d = {12'h000, count_q};
        end
        start_d = 1'b1;
        st_d = M_WAIT;
      end
      M_WAIT: begin
        if (bus_done) begin
          if (b_rd_q) begin
            rd_data_d = bus_rdata;
            rd_valid_d = 1'b1;
          end
          if (!last_q) begin
            idx_d = idx_q + 3'd1;
            st_d = M_ISSUE;
          end else if (cmd_q == FCD_BUFWR && !commit_q) begin
            left_d = {1'b0, count_q} + 5'h01;
            first_d = 1'b1;
            wready_d = 1'b1;
            st_d = M_WORD;
          end else begin
            case (cmd_q)
              FCD_RESET: begin
                autosel_d = 1'b0;
                erase_d = 1'b0;
              end
              FCD_AUTOSEL: autosel_d = 1'b1;
              FCD_BYP_ENTER: bypass_d = 1'b1;
              FCD_BYP_EXIT: bypass_d = 1'b0;
              FCD_SECT_ERASE: erase_d = 1'b1;
              FCD_SUSPEND: begin
                erase_d = 1'b0;
                susp_d = 1'b1;
              end
              FCD_RESUME: begin
                erase_d = 1'b1;
                susp_d = 1'b0;
              end
              default: begin
              end
            endcase
            done_d = 1'b1;
            ready_d = 1'b1;
            st_d = M_IDLE;
          end
        end
      end
      M_WORD: begin
        if (i_word_valid && wready_q) begin
          wready_d = 1'b0;
          if (first_q) begin
            page_d = i_word_addr[21:`FCD_PAGE_BITS];
            b_addr_d = i_word_addr;
          end else begin
            // Later words forced into the first word's page
            b_addr_d = {page_q, i_word_addr[`FCD_PAGE_BITS-1:0]};
          end
          first_d = 1'b0;
          b_data_d = i_word_data;
          b_rd_d = 1'b0;
          left_d = left_q - 5'h01;
          start_d = 1'b1;
          st_d = M_WWAIT;
        end
      end
      default: begin
        if (bus_done) begin
          if (left_q == 5'h00) begin
            b_addr_d = sector_of(addr_q);
            b_data_d = {8'h00, `FCD_D_COMMIT};
            commit_d = 1'b1;
            last_d = 1'b1;
            start_d = 1'b1;
            st_d = M_WAIT;
          end else begin
            wready_d = 1'b1;
            st_d = M_WORD;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= M_IDLE;
      cmd_q <= FCD_READ;
      addr_q <= 22'h000000;
      data_q <= 16'h0000;
      count_q <= 4'h0;
      idx_q <= 3'd0;
      left_q <= 5'h00;
      page_q <= 18'h00000;
      first_q <= 1'b0;
      commit_q <= 1'b0;
      last_q <= 1'b0;
      start_q <= 1'b0;
      b_rd_q <= 1'b0;
      b_addr_q <= 22'h000000;
      b_data_q <= 16'h0000;
      ready_q <= 1'b1;
      refused_q <= 1'b0;
      done_q <= 1'b0;
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      wready_q <= 1'b0;
      bypass_q <= 1'b0;
      autosel_q <= 1'b0;
      erase_q <= 1'b0;
      susp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      data_q <= data_d;
      count_q <= count_d;
      idx_q <= idx_d;
      left_q <= left_d;
      page_q <= page_d;
      first_q <= first_d;
      commit_q <= commit_d;
      last_q <= last_d;
      start_q <= start_d;
      b_rd_q <= b_rd_d;
      b_addr_q <= b_addr_d;
      b_data_q <= b_data_d;
      ready_q <= ready_d;
      refused_q <= refused_d;
      done_q <= done_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      wready_q <= wready_d;
      bypass_q <= bypass_d;
      autosel_q <= autosel_d;
      erase_q <= erase_d;
      susp_q <= susp_d;
    end
  end

  fcd_bus_cycle u_bus (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(start_q),
    .i_rd(b_rd_q),
    .i_addr(b_addr_q),
    .i_wdata(b_data_q),
    .i_dq(i_dq),
    .o_done(bus_done),
    .o_rdata(bus_rdata),
    .o_ce_n(o_ce_n),
    .o_we_n(o_we_n),
    .o_oe_n(o_oe_n),
    .o_addr(o_addr),
    .o_dq(o_dq),
    .o_dq_oe_n(o_dq_oe_n)
  );

  assign o_cmd_ready = ready_q;
  assign o_cmd_refused = refused_q;
  assign o_done = done_q;
  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_word_ready = wready_q;
  assign o_bypass = bypass_q;
  assign o_autosel = autosel_q;
  assign o_suspended = susp_q;

endmodule

// ===== tb/fcd_host_chk.sv
`timescale 1ns/1ps
module fcd_host_chk import fcd_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input fcd_cmd_e i_cmd,
  input wire logic [4:0] i_count,
  input wire logic o_cmd_ready,
  input wire logic o_cmd_refused,
  input wire logic o_bypass,
  input wire logic o_suspended,
  input wire logic o_ce_n,
  input wire logic o_we_n,
  input wire logic o_oe_n,
  input wire logic [21:0] o_addr,
  input wire logic [15:0] o_dq,
  input wire logic o_dq_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic take;
  assign take = i_cmd_valid && o_cmd_ready;
  ////////////////////////////////////////////////////////////////////////
  AST_TAKE: assert property (take |=> o_cmd_refused == o_cmd_ready)
    else $error("take answer wrong");
  AST_BYP_OUT: assert property (take && !o_bypass
    && i_cmd == FCD_BYP_PROG |=> o_cmd_refused)
    else $error("bypass program not refused");
  AST_BYP_IN: assert property (take && o_bypass && !(i_cmd inside
    {FCD_READ, FCD_BYP_PROG, FCD_BYP_EXIT}) |=> o_cmd_refused)
    else $error("command in bypass not refused");
  AST_COUNT: assert property (take && i_cmd == FCD_BUFWR
    && i_count > 5'h0f |=> o_cmd_refused) else $error("count not refused");
  AST_RESUME: assert property (take && i_cmd == FCD_RESUME
    && !o_suspended |=> o_cmd_refused) else $error("resume not refused");
  AST_SUSP: assert property (take && i_cmd == FCD_SUSPEND && o_suspended
    |=> o_cmd_refused) else $error("suspend not refused");
  AST_WE_WIDTH: assert property ($fell(o_we_n) |->
    (!o_we_n && !o_ce_n && o_oe_n && !o_dq_oe_n)[*8] ##1
    (!o_we_n && !o_ce_n && o_oe_n && !o_dq_oe_n) ##1 o_we_n)
    else $error("write pulse wrong");
  AST_DATA_HOLD: assert property ($rose(o_we_n) |-> !o_ce_n && !o_dq_oe_n
    && $stable(o_dq) && $stable(o_addr)) else $error("data not held");
  AST_UNLOCK: assert property ($fell(o_we_n) && o_dq[7:0] == 8'h55 &&
    o_addr[11:0] == 12'h2aa |-> o_addr[21:12] == 10'h000
    && o_dq[15:8] == 8'h00) else $error("unlock upper bits set");
  AST_RD_NODRV: assert property (!o_oe_n |-> o_dq_oe_n && o_we_n)
    else $error("drive during read");
endmodule
bind fcd_host fcd_host_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_count(i_count),
  .o_cmd_ready(o_cmd_ready), .o_cmd_refused(o_cmd_refused),
  .o_bypass(o_bypass), .o_suspended(o_suspended), .o_ce_n(o_ce_n),
  .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq(o_dq),
  .o_dq_oe_n(o_dq_oe_n));

// ===== tb/fcd_flash_model.sv
`timescale 1ns/1ps
module fcd_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEV_ID1 = 16'h1101, // Arbitrary value
  parameter logic [15:0] DEV_ID2 = 16'h1102, // Arbitrary value
  parameter logic [15:0] DEV_ID3 = 16'h1103, // Arbitrary value
  parameter logic [15:0] SEC_LOCK = 16'h0080,
  parameter int ACC_NS = 60
) (
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [21:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq
);
  logic [15:0] mem [logic [21:0]];
  logic [21:0] log_a [$];
  logic [15:0] log_d [$];
  logic [21:0] la;
  logic [15:0] rd;
  logic [15:0] last = 16'h0000;
  logic wr = 0, asel = 0, byp = 0, prog = 0;
  int st = 0, nwr = 0;

  task automatic decode(input logic [21:0] a, input logic [15:0] d);
    log_a.push_back(a);
    log_d.push_back(d);
    nwr++;
    if (prog) begin
      mem[a] = d;
      prog = 0;
    end else if (byp) begin
      if (d[7:0] == 8'ha0) prog = 1;
      else if (d[7:0] == 8'h90) st = 9;
      else if (st == 9 && d[7:0] == 8'h00) begin
        byp = 0;
        st = 0;
      end
    end else if (d[7:0] == 8'hf0) begin
      asel = 0;
      st = 0;
    end else if (st == 0 && a[11:0] == 12'h555 && d[7:0] == 8'haa) st = 1;
    else if (st == 1 && a[11:0] == 12'h2aa && d[7:0] == 8'h55) st = 2;
    else if (st == 2) begin
      st = 0;
      asel = asel | (d[7:0] == 8'h90);
      prog = d[7:0] == 8'ha0;
      byp = d[7:0] == 8'h20;
    end else st = 0;
  endtask

  // Address on the later falling strobe
  always @(negedge i_we_n or negedge i_ce_n) begin
    if (!i_we_n && !i_ce_n) begin
      la = i_addr;
      wr = 1;
    end
  end
  // Data on the first rising strobe
  always @(posedge i_we_n or posedge i_ce_n) begin
    if (wr) begin
      wr = 0;
      decode(la, i_dq);
    end
  end

  always @(i_addr, asel, nwr) begin
    if (asel) begin
      case (i_addr[7:0])
        8'h00: rd = MAKER_ID;
        8'h01: rd = DEV_ID1;
        8'h0e: rd = DEV_ID2;
        8'h0f: rd = DEV_ID3;
        8'h02: rd = {15'h0000, i_addr[15]};
        8'h03: rd = SEC_LOCK;
        default: rd = 16'h0000;
      endcase
    end else if (mem.exists(i_addr)) rd = mem[i_addr];
    else rd = i_addr[15:0] ^ 16'h3c3c;
  end
  always @(posedge i_oe_n) last = rd;
  // Released bus shows the inverse, not a stale copy
  assign #ACC_NS o_dq = (!i_ce_n && !i_oe_n) ? rd : ~last;
endmodule

// ===== tb/fcd_host_tb_top.sv
`timescale 1ns/1ps
module fcd_host_tb_top import fcd_pkg::*;;
  localparam logic [15:0] MK = 16'h00a5; // Arbitrary value
  localparam logic [15:0] D1 = 16'h1101; // Arbitrary value
  localparam logic [15:0] D2 = 16'h1102; // Arbitrary value
  localparam logic [15:0] D3 = 16'h1103; // Arbitrary value
  localparam logic [15:0] SL = 16'h0080;
  logic i_clk = 0, i_resetn = 0, i_cmd_valid = 0, i_word_valid = 0;
  fcd_cmd_e i_cmd = FCD_READ;
  logic [21:0] i_addr = 22'h0, i_word_addr = 22'h0, o_addr;
  logic [15:0] i_data = 16'h0, i_word_data = 16'h0;
  logic [4:0] i_count = 5'h0;
  logic o_cmd_ready, o_cmd_refused, o_done, o_rd_valid, o_word_ready;
  logic o_bypass, o_autosel, o_suspended, o_ce_n, o_we_n, o_oe_n, o_dq_oe_n;
  logic [15:0] o_rd_data, o_dq, f_dq, dq_w;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  logic [21:0] wq_a [$];
  logic [15:0] wq_d [$];

  always #2 i_clk = ~i_clk;
  assign dq_w = o_dq_oe_n ? f_dq : o_dq;

  fcd_host dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_addr(i_addr),
    .i_data(i_data), .i_count(i_count), .o_cmd_ready(o_cmd_ready),
    .o_cmd_refused(o_cmd_refused), .o_done(o_done), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .i_word_valid(i_word_valid),
    .i_word_addr(i_word_addr), .i_word_data(i_word_data),
    .o_word_ready(o_word_ready), .o_bypass(o_bypass), .o_autosel(o_autosel),
    .o_suspended(o_suspended), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
    .o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
    .i_dq(dq_w));
  fcd_flash_model #(.MAKER_ID(MK), .DEV_ID1(D1), .DEV_ID2(D2), .DEV_ID3(D3),
    .SEC_LOCK(SL)) u_flash (.i_ce_n(o_ce_n), .i_we_n(o_we_n),
    .i_oe_n(o_oe_n), .i_addr(o_addr), .i_dq(dq_w), .o_dq(f_dq));
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (i_word_valid && o_word_ready) begin
      void'(wq_a.pop_front());
      void'(wq_d.pop_front());
    end
    i_word_valid <= wq_a.size() != 0;
    if (wq_a.size() != 0) begin
      i_word_addr <= wq_a[0];
      i_word_data <= wq_d[0];
    end
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_log(input int i, input logic [21:0] a,
                         input logic [15:0] d);
    check(u_flash.log_a[i], a);
    check(u_flash.log_d[i], d);
  endtask
  task automatic cmd(input fcd_cmd_e c, input logic [21:0] a,
                     input logic [15:0] d, input logic [4:0] n,
                     input logic refused);
    int k;
    u_flash.log_a.delete();
    u_flash.log_d.delete();
    i_cmd_valid <= 1;
    i_cmd <= c;
    i_addr <= a;
    i_data <= d;
    i_count <= n;
    do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
    i_cmd_valid <= 0;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_done !== 1'b1 && o_cmd_refused !== 1'b1 && k < 3000);
    check({o_done, o_cmd_refused}, {!refused, refused});
    check(o_rd_valid, !refused && c inside {FCD_READ, FCD_AUTOSEL});
    @(posedge i_clk);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_read();
    cmd(FCD_READ, 22'h012345, 16'h0, 5'h0, 0);
    check(o_rd_data, 16'h2345 ^ 16'h3c3c);
    check(u_flash.log_a.size(), 0);
  endtask
  task automatic s_autosel();
    logic [21:0] aa[7] = '{22'h0, 22'h1, 22'he, 22'hf, 22'h3, 22'h8002,
                           22'h10002};
    logic [15:0] ev[7] = '{MK, D1, D2, D3, SL, 16'h1, 16'h0};
    for (int i = 0; i < 7; i++) begin
      cmd(FCD_AUTOSEL, aa[i], 16'h0, 5'h0, 0);
      check(o_rd_data, ev[i]);
    end
    chk_log(0, 22'h555, 16'h00aa);
    chk_log(1, 22'h2aa, 16'h0055);
    chk_log(2, 22'h555, 16'h0090);
    check(o_autosel, 1);
    cmd(FCD_RESET, 22'h0, 16'h0, 5'h0, 0);
    chk_log(0, 22'h0, 16'h00f0);
    check(o_autosel, 0);
    cmd(FCD_READ, 22'h000001, 16'h0, 5'h0, 0);
    check(o_rd_data, 16'h0001 ^ 16'h3c3c);
  endtask
  task automatic s_prog();
    cmd(FCD_PROGRAM, 22'h2a0010, 16'hbeef, 5'h0, 0);
    chk_log(2, 22'h555, 16'h00a0);
    chk_log(3, 22'h2a0010, 16'hbeef);
    cmd(FCD_READ, 22'h2a0010, 16'h0, 5'h0, 0);
    check(o_rd_data, 16'hbeef);
  endtask
  task automatic s_bypass();
    cmd(FCD_BYP_PROG, 22'h001234, 16'h1357, 5'h0, 1);
    cmd(FCD_BYP_ENTER, 22'h0, 16'h0, 5'h0, 0);
    chk_log(2, 22'h555, 16'h0020);
    check(o_bypass, 1);
    cmd(FCD_AUTOSEL, 22'h0, 16'h0, 5'h0, 1);
    cmd(FCD_BYP_PROG, 22'h001234, 16'h1357, 5'h0, 0);
    chk_log(0, 22'h0, 16'h00a0);
    chk_log(1, 22'h001234, 16'h1357);
    cmd(FCD_BYP_EXIT, 22'h0, 16'h0, 5'h0, 0);
    chk_log(0, 22'h0, 16'h0090);
    chk_log(1, 22'h0, 16'h0000);
    check(o_bypass, 0);
    cmd(FCD_READ, 22'h001234, 16'h0, 5'h0, 0);
    check(o_rd_data, 16'h1357);
  endtask
  task automatic s_buf();
    cmd(FCD_BUFWR, 22'h0c8005, 16'h0, 5'h10, 1);
    wq_a = '{22'h0c8005, 22'h0c8017};
    wq_d = '{16'h1111, 16'h2222};
    cmd(FCD_BUFWR, 22'h0c8005, 16'h0, 5'h01, 0);
    chk_log(2, 22'h0c8000, 16'h0025);
    chk_log(3, 22'h0c8000, 16'h0001);
    chk_log(4, 22'h0c8005, 16'h1111);
    chk_log(5, 22'h0c8007, 16'h2222);
    chk_log(6, 22'h0c8000, 16'h0029);
    check(u_flash.log_a.size(), 7);
    cmd(FCD_BUFABORT, 22'h0, 16'h0, 5'h0, 0);
    chk_log(2, 22'h555, 16'h00f0);
  endtask
  task automatic s_erase();
    cmd(FCD_SUSPEND, 22'h0, 16'h0, 5'h0, 1);
    cmd(FCD_RESUME, 22'h0, 16'h0, 5'h0, 1);
    cmd(FCD_CHIP_ERASE, 22'h0, 16'h0, 5'h0, 0);
    chk_log(2, 22'h555, 16'h0080);
    chk_log(5, 22'h555, 16'h0010);
    cmd(FCD_SECT_ERASE, 22'h1f1234, 16'h0, 5'h0, 0);
    chk_log(5, 22'h1f0000, 16'h0030);
    cmd(FCD_QUERY, 22'h0, 16'h0, 5'h0, 1);
    cmd(FCD_SUSPEND, 22'h0, 16'h0, 5'h0, 0);
    chk_log(0, 22'h0, 16'h00b0);
    check(o_suspended, 1);
    cmd(FCD_SUSPEND, 22'h0, 16'h0, 5'h0, 1);
    cmd(FCD_RESUME, 22'h0, 16'h0, 5'h0, 0);
    chk_log(0, 22'h0, 16'h0030);
    check(o_suspended, 0);
    cmd(FCD_RESET, 22'h0, 16'h0, 5'h0, 0);
    cmd(FCD_QUERY, 22'h0, 16'h0, 5'h0, 0);
    chk_log(0, 22'h055, 16'h0098);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge i_clk);
    i_resetn <= 1;
    s_read();
    s_autosel();
    s_prog();
    s_bypass();
    s_buf();
    s_erase();
    complete_run();
  end
endmodule
